// ==== srw_defs.svh ====
// constants for the reset, watchdog and power-mode controller
`ifndef SRW_DEFS_SVH
`define SRW_DEFS_SVH

// clock and oscillator rates
`define SRW_CLK_HZ 100000000
`define SRW_CLK_PERIOD_NS 10
`define SRW_LSO_HZ 32000
`define SRW_WCO_HZ 32768
`define SRW_IMO_HZ 8000000
// main clock cycles per oscillator tick (3125 and 3051)
`define SRW_LSO_DIV (`SRW_CLK_HZ / `SRW_LSO_HZ)
`define SRW_WCO_DIV (`SRW_CLK_HZ / `SRW_WCO_HZ)
// least time the system reset stays asserted after its last source
`define SRW_RST_HOLD_NS 160
`define SRW_RST_HOLD_CYC ((`SRW_RST_HOLD_NS + `SRW_CLK_PERIOD_NS - 1) / `SRW_CLK_PERIOD_NS)

// byte offsets
`define SRW_OFF_CAUSE 8'h00
`define SRW_OFF_CTRL 8'h04
`define SRW_OFF_STAT 8'h08
`define SRW_OFF_WD_BASE 8'h40
`define SRW_WD_SUB_CFG 4'h0
`define SRW_WD_SUB_MATCH 4'h4
`define SRW_WD_SUB_COUNT 4'h8

// control fields
`define SRW_CTRL_SW_RST 0
`define SRW_CTRL_PROT_RST_EN 1
`define SRW_CTRL_ULP 2
`define SRW_CTRL_HIB_REQ 3
`define SRW_CTRL_LF_SEL 4
`define SRW_CTRL_PERI_EN 5
`define SRW_CTRL_W 6
`define SRW_CTRL_RST 6'h00

// watchdog counter configuration fields
`define SRW_CFG_EN 0
`define SRW_CFG_RST_EN 1
`define SRW_CFG_CLR 2
`define SRW_CFG_W 3
`define SRW_CFG_RST_BASIC 3'h3
`define SRW_CFG_RST_MC 3'h0
`define SRW_MATCH_RST 32'h0000FFFF
`define SRW_N_WD 7

// reset cause fields
`define SRW_CAUSE_POR 0
`define SRW_CAUSE_DROP 1
`define SRW_CAUSE_EXT 2
`define SRW_CAUSE_BWD 3
`define SRW_CAUSE_MC0 4
`define SRW_CAUSE_MC1 5
`define SRW_CAUSE_SW 6
`define SRW_CAUSE_PROT 7
`define SRW_CAUSE_HIB 8
`define SRW_CAUSE_W 9
`define SRW_CAUSE_RST 9'h001

// main clock frequency codes in MHz (50 and 25)
`define SRW_HF_LP_MHZ 8'h32
`define SRW_HF_ULP_MHZ 8'h19

`endif

// ==== srw_partner.sv ====
// model of the external reset driver and the supply monitor
`timescale 1ns/1ps
`default_nettype none
module srw_partner (
  // clock
  input wire logic mclk_i,
  // commands from the bench
  input wire logic ext_req_i,
  input wire logic drop_req_i,
  input wire logic [3:0] hold_i,
  // pins toward the device
  output logic ext_reset_n_o,
  output logic supply_drop_reset_o
);
  logic [3:0] ext_cnt_reg = 4'h0;
  logic [3:0] drop_cnt_reg = 4'h0;
  // pin idles high through its pull-up; the driver only ever pulls it low
  assign ext_reset_n_o = (ext_cnt_reg == 4'h0);
  assign supply_drop_reset_o = (drop_cnt_reg != 4'h0);
  // hold length is a command input, so both short and long events are possible
  always @(posedge mclk_i) begin
    ext_cnt_reg <= ext_req_i ? hold_i : ext_cnt_reg - (ext_cnt_reg != 4'h0);
    drop_cnt_reg <= drop_req_i ? hold_i : drop_cnt_reg - (drop_cnt_reg != 4'h0);
  end
endmodule // srw_partner
`default_nettype wire

// ==== srw_pkg.sv ====
// types shared by the reset, watchdog and power-mode controller
package srw_pkg;
  typedef logic [31:0] srw_word_t;
  typedef enum logic [1:0] {
    SRW_PWR_ACTIVE = 2'b00,
    SRW_PWR_DEEP = 2'b01,
    SRW_PWR_HIB = 2'b10
  } srw_pwr_t;
endpackage

// ==== srw_top.sv ====
// reset combiner, watchdogs and power-mode sequencer with avalon register access
//
// Operation
// R1: power-on reset holds the whole device until the supply has ramped.
// R2: supply drop below logic minimum issues a reset.
// R3: external reset input is active low, kept high otherwise.
// R4: unserviced watchdog reaching its timeout resets the device.
// R5: firmware can reset the whole device by writing a register.
// R6: protection fault raises an interrupt or a reset, as configured.
// R7: hibernate freezes state; any wakeup from hibernate resets the device.
// R8: reset causes are recorded in a register that survives system resets.
// R9: reset sources act asynchronously and return logic to a known state; here only power-on, pin and supply act without a clock edge.
// R10: basic watchdog is one free-running 16-bit up-counter on the slow oscillator.
// R11: each multi-counter watchdog has two 16-bit and one 32-bit counter, modes.
// R12: every 16-bit watchdog counter can trigger a device reset.
// R13: every watchdog counter can raise an interrupt on match.
// R14: basic watchdog runs and wakes in all system low power modes.
// R15: multi-counter watchdogs run on selectable low-frequency clock, not in hibernate.
// R16: system deep sleep entered only when both CPUs request deep sleep.
// R17: CPU sleep halts that CPU while the system stays running.
// R18: ultra low power lowers core voltage and limits clock speed.
// R19: main clock from internal oscillator via locked loop, 50 or 25 MHz.
// R20: slow oscillator nominally 32 kHz and active in every power mode.
// R21: cause flags stay set until cleared; new causes add flags.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "srw_defs.svh"
module srw_top (
  // clock and power-on reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire srw_pkg::srw_word_t avs_writedata_i,
  output srw_pkg::srw_word_t avs_readdata_o,
  output logic avs_waitrequest_o,
  // reset sources
  input wire logic ext_reset_n_i,
  input wire logic supply_drop_reset_i,
  input wire logic prot_fault_i,
  // cpu power requests and wakeup
  input wire logic [1:0] cpu_sleep_i,
  input wire logic [1:0] cpu_deep_i,
  input wire logic wake_i,
  // system reset and events
  output logic sys_reset_n_o,
  output logic [`SRW_N_WD-1:0] wdog_irq_o,
  output logic prot_fault_irq_o,
  // power and clock control
  output logic [1:0] cpu_halt_o,
  output logic sys_deep_sleep_o,
  output logic hibernate_freeze_o,
  output logic hf_clk_en_o,
  output logic hf_src_fll_o,
  output logic [7:0] hf_clk_mhz_o,
  output logic vcore_ulp_o,
  output logic periph_clk_en_o
);
  import srw_pkg::*;

  localparam int unsigned N = `SRW_N_WD;

  // oscillator tick dividers
  logic [11:0] lso_div_reg;
  logic [11:0] wco_div_reg;
  logic lso_tick_reg;
  logic wco_tick_reg;
  // bus
  logic wait_reg;
  srw_word_t rdata_reg;
  // registers and state
  logic [`SRW_CAUSE_W-1:0] cause_reg;
  logic [`SRW_CAUSE_W-1:0] cause_next;
  logic [`SRW_CTRL_W-1:0] ctrl_reg;
  srw_pwr_t pwr_reg;
  srw_pwr_t pwr_next;
  logic [7:0] hold_reg;
  logic sys_rst_n_reg;
  // output flops
  logic [N-1:0] wdog_irq_reg;
  logic prot_irq_reg;
  logic [1:0] cpu_halt_reg;
  logic deep_reg;
  logic freeze_reg;
  logic hf_en_reg;
  logic hf_src_reg;
  logic [7:0] hf_mhz_reg;
  logic ulp_reg;
  logic peri_reg;
  // per-counter wires
  logic [`SRW_CFG_W-1:0] wd_cfg [N];
  logic [31:0] wd_match_val [N];
  logic [31:0] wd_count [N];
  logic [N-1:0] wd_match;
  logic [N-1:0] wd_rst;

  // slow oscillator tick, nominally 32 kHz, never gated by power mode
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lso_div_reg <= 12'h000;
      lso_tick_reg <= 1'b0;
    end else begin
      lso_tick_reg <= (lso_div_reg == 12'(`SRW_LSO_DIV - 1)); // [R20]
      lso_div_reg <= (lso_div_reg == 12'(`SRW_LSO_DIV - 1)) ? 12'h000 : lso_div_reg + 12'h001;
    end
  end

  // watch crystal tick, the alternative low-frequency source
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wco_div_reg <= 12'h000;
      wco_tick_reg <= 1'b0;
    end else begin
      wco_tick_reg <= (wco_div_reg == 12'(`SRW_WCO_DIV - 1));
      wco_div_reg <= (wco_div_reg == 12'(`SRW_WCO_DIV - 1)) ? 12'h000 : wco_div_reg + 12'h001;
    end
  end

  // low-frequency clock select for the multi-counter watchdogs
  wire lf_tick = ctrl_reg[`SRW_CTRL_LF_SEL] ? wco_tick_reg : lso_tick_reg; // [R15]
  wire sys_rst_active = ~sys_rst_n_reg;

  // bus decode
  wire req = avs_read_i | avs_write_i;
  wire wr_fire = avs_write_i & ~wait_reg;
  wire [7:0] wd_off = avs_address_i - `SRW_OFF_WD_BASE;
  wire [2:0] wd_idx = wd_off[6:4];
  wire [3:0] wd_sub = wd_off[3:0];
  wire wd_hit = (avs_address_i >= `SRW_OFF_WD_BASE) && (wd_off[7:4] < 4'(N));
  wire sel_cause = (avs_address_i == `SRW_OFF_CAUSE);
  wire sel_ctrl = (avs_address_i == `SRW_OFF_CTRL);
  wire sel_stat = (avs_address_i == `SRW_OFF_STAT);

  // watchdog counters: index 0 basic, 1-3 first multi-counter, 4-6 second
  for (genvar g = 0; g < N; g++) begin : g_wd
    localparam bit IS_BASIC = (g == 0);
    localparam bit IS_WIDE = (g == 3) || (g == 6);
    localparam logic [`SRW_CFG_W-1:0] CFG_RST = IS_BASIC ? `SRW_CFG_RST_BASIC : `SRW_CFG_RST_MC;
    logic [`SRW_CFG_W-1:0] cfg_reg;
    logic [31:0] match_reg;
    wire sel = wd_hit && (wd_idx == 3'(g));
    srw_wd_if u_if ();

    // multi-counter units stop in hibernate, the basic one keeps running
    assign u_if.en = cfg_reg[`SRW_CFG_EN] & (IS_BASIC | (pwr_reg != SRW_PWR_HIB)); // [R14] [R15]
    assign u_if.tick = IS_BASIC ? lso_tick_reg : lf_tick; // [R10]
    // writing the count word services the counter; system reset clears it
    assign u_if.kick = sys_rst_active | (wr_fire & sel & (wd_sub == `SRW_WD_SUB_COUNT)); // [R4]
    assign u_if.clr_on_match = cfg_reg[`SRW_CFG_CLR]; // [R11]
    assign u_if.match_val = match_reg;
    assign wd_cfg[g] = cfg_reg;
    assign wd_match_val[g] = match_reg;
    assign wd_count[g] = u_if.count;
    assign wd_match[g] = u_if.match_p; // [R13]
    // only the 16-bit counters may reset the device
    assign wd_rst[g] = u_if.match_p & cfg_reg[`SRW_CFG_RST_EN] & ~IS_WIDE; // [R12]

    srw_wdog_cnt #(
      .W(IS_WIDE ? 32 : 16) // [R11]
    ) u_cnt (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .wd(u_if.ctr)
    );

    // configuration and match value, back to defaults on every system reset
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        cfg_reg <= CFG_RST;
        match_reg <= `SRW_MATCH_RST;
      end else if (sys_rst_active) begin
        cfg_reg <= CFG_RST;
        match_reg <= `SRW_MATCH_RST;
      end else if (wr_fire && sel) begin
        if (wd_sub == `SRW_WD_SUB_CFG) begin
          cfg_reg <= avs_writedata_i[`SRW_CFG_W-1:0];
        end
        if (wd_sub == `SRW_WD_SUB_MATCH) begin
          match_reg <= IS_WIDE ? avs_writedata_i : {16'h0000, avs_writedata_i[15:0]};
        end
      end
    end
  end

  // reset request sources seen in the clock domain
  wire rst_bwd = wd_rst[0]; // [R4]
  wire rst_mc0 = |wd_rst[3:1];
  wire rst_mc1 = |wd_rst[6:4];
  wire rst_sw = wr_fire & sel_ctrl & avs_writedata_i[`SRW_CTRL_SW_RST]; // [R5]
  wire rst_prot = prot_fault_i & ctrl_reg[`SRW_CTRL_PROT_RST_EN]; // [R6]
  wire hib_wake = (pwr_reg == SRW_PWR_HIB) & (wake_i | wd_match[0]); // [R7]
  wire sync_rst_req = ~sys_rst_active & (rst_bwd | rst_mc0 | rst_mc1 | rst_sw | rst_prot | hib_wake);

  // pin and supply sources reset the hold logic without any clock edge
  wire any_rst_b = rst_b_i & ext_reset_n_i & ~supply_drop_reset_i; // [R1] [R2] [R3] [R9]

  // reset stretcher: power-on, pin and supply restart the hold count at any time, the other sources only outside a system reset
  always_ff @(posedge mclk_i or negedge any_rst_b) begin
    if (!any_rst_b) begin
      hold_reg <= 8'(`SRW_RST_HOLD_CYC); // [R9]
      sys_rst_n_reg <= 1'b0;
    end else if (sync_rst_req) begin
      hold_reg <= 8'(`SRW_RST_HOLD_CYC);
      sys_rst_n_reg <= 1'b0;
    end else begin
      hold_reg <= (hold_reg != 8'h00) ? hold_reg - 8'h01 : 8'h00;
      sys_rst_n_reg <= (hold_reg == 8'h00);
    end
  end

  // cause record: only power-on resets it, firmware writes of ones clear flags, new causes are ORed in
  wire [`SRW_CAUSE_W-1:0] cause_set = {
    hib_wake, ~sys_rst_active & rst_prot, rst_sw, rst_mc1, rst_mc0, rst_bwd,
    ~ext_reset_n_i, supply_drop_reset_i, 1'b0}; // [R8]
  wire [`SRW_CAUSE_W-1:0] cause_clr = (wr_fire & sel_cause) ? avs_writedata_i[`SRW_CAUSE_W-1:0] : '0;
  // a source active in the clearing cycle keeps its flag set
  assign cause_next = (cause_reg & ~cause_clr) | cause_set; // [R21]

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cause_reg <= `SRW_CAUSE_RST; // [R8]
    end else begin
      cause_reg <= cause_next;
    end
  end

  // control register; the software reset bit is a strobe and is not stored
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= `SRW_CTRL_RST;
    end else if (sys_rst_active) begin
      ctrl_reg <= `SRW_CTRL_RST;
    end else if (wr_fire && sel_ctrl) begin
      ctrl_reg <= avs_writedata_i[`SRW_CTRL_W-1:0] & ~(`SRW_CTRL_W'(1) << `SRW_CTRL_SW_RST);
    end
  end

  // power mode sequencer
  wire both_deep = &cpu_deep_i; // [R16]
  wire deep_wake = wake_i | (|wd_match) | ~both_deep;
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      SRW_PWR_ACTIVE: begin
        if (both_deep) begin
          pwr_next = ctrl_reg[`SRW_CTRL_HIB_REQ] ? SRW_PWR_HIB : SRW_PWR_DEEP; // [R16] [R7]
        end
      end
      SRW_PWR_DEEP: begin
        if (deep_wake) begin
          pwr_next = SRW_PWR_ACTIVE; // [R14] [R15]
        end
      end
      // hibernate is left only through a system reset, the wake reset among them
      SRW_PWR_HIB: begin
        pwr_next = SRW_PWR_HIB; // [R7]
      end
      default: begin
        pwr_next = SRW_PWR_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwr_reg <= SRW_PWR_ACTIVE;
    end else if (sys_rst_active) begin
      pwr_reg <= SRW_PWR_ACTIVE;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  // event outputs: watchdog matches as one-cycle pulses, protection interrupt follows the fault one cycle later
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wdog_irq_reg <= '0;
      prot_irq_reg <= 1'b0;
    end else begin
      wdog_irq_reg <= wd_match; // [R13]
      prot_irq_reg <= prot_fault_i & ~ctrl_reg[`SRW_CTRL_PROT_RST_EN]; // [R6]
    end
  end

  // halt, sleep, freeze and clock enables follow the next mode so they change with it; clock rate and core voltage follow the ULP bit
  wire next_active = (pwr_next == SRW_PWR_ACTIVE) & ~sys_rst_active;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_halt_reg <= 2'h3;
      deep_reg <= 1'b0;
      freeze_reg <= 1'b0;
      hf_en_reg <= 1'b0;
      hf_src_reg <= 1'b1;
      hf_mhz_reg <= `SRW_HF_LP_MHZ;
      ulp_reg <= 1'b0;
      peri_reg <= 1'b0;
    end else begin
      // a sleeping cpu halts while the system keeps its clocks
      cpu_halt_reg <= cpu_sleep_i | cpu_deep_i | {2{~next_active}}; // [R17]
      deep_reg <= (pwr_next == SRW_PWR_DEEP); // [R16]
      freeze_reg <= (pwr_next == SRW_PWR_HIB); // [R7]
      hf_en_reg <= next_active;
      hf_src_reg <= 1'b1; // [R19]
      hf_mhz_reg <= ctrl_reg[`SRW_CTRL_ULP] ? `SRW_HF_ULP_MHZ : `SRW_HF_LP_MHZ; // [R18] [R19]
      ulp_reg <= ctrl_reg[`SRW_CTRL_ULP]; // [R18]
      // other peripheral clocks stay off until firmware opens them
      peri_reg <= ctrl_reg[`SRW_CTRL_PERI_EN] & next_active; // [R19]
    end
  end

  // read selection
  wire [31:0] wd_rdata = (wd_sub == `SRW_WD_SUB_CFG) ? {29'h0, wd_cfg[wd_idx]} :
                         (wd_sub == `SRW_WD_SUB_MATCH) ? wd_match_val[wd_idx] :
                         (wd_sub == `SRW_WD_SUB_COUNT) ? wd_count[wd_idx] : 32'h0000_0000;
  wire [31:0] stat_rdata = {24'h0, 1'b0, ulp_reg, cpu_halt_reg, cpu_deep_i, pwr_reg};
  wire [31:0] rd_mux = sel_cause ? {23'h0, cause_reg} :
                       sel_ctrl ? {26'h0, ctrl_reg} :
                       sel_stat ? stat_rdata :
                       wd_hit ? wd_rdata : 32'h0000_0000;

  // one wait state: waitrequest drops in the second cycle of a request
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= ~(req & wait_reg);
      if (avs_read_i && wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign sys_reset_n_o = sys_rst_n_reg;
  assign wdog_irq_o = wdog_irq_reg;
  assign prot_fault_irq_o = prot_irq_reg;
  assign cpu_halt_o = cpu_halt_reg;
  assign sys_deep_sleep_o = deep_reg;
  assign hibernate_freeze_o = freeze_reg;
  assign hf_clk_en_o = hf_en_reg;
  assign hf_src_fll_o = hf_src_reg;
  assign hf_clk_mhz_o = hf_mhz_reg;
  assign vcore_ulp_o = ulp_reg;
  assign periph_clk_en_o = peri_reg;
endmodule // srw_top
`default_nettype wire

// ==== srw_top_sva.sv ====
// port-level assertions for the reset, watchdog and power-mode controller
`timescale 1ns/1ps
`default_nettype none
`include "srw_defs.svh"
module srw_top_sva (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // register bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire srw_pkg::srw_word_t avs_writedata_i,
  input wire logic avs_waitrequest_o,
  // reset sources and power requests
  input wire logic ext_reset_n_i,
  input wire logic supply_drop_reset_i,
  input wire logic prot_fault_i,
  input wire logic [1:0] cpu_sleep_i,
  input wire logic [1:0] cpu_deep_i,
  input wire logic wake_i,
  // outputs under watch
  input wire logic sys_reset_n_o,
  input wire logic [`SRW_N_WD-1:0] wdog_irq_o,
  input wire logic prot_fault_irq_o,
  input wire logic [1:0] cpu_halt_o,
  input wire logic sys_deep_sleep_o,
  input wire logic hibernate_freeze_o,
  input wire logic hf_src_fll_o,
  input wire logic [7:0] hf_clk_mhz_o,
  input wire logic vcore_ulp_o
);
  import srw_pkg::*;
  // one clock domain, so clock and disable are given once
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // bus answers with exactly one wait state
  AST_ONE_WAIT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus request not answered after one wait state");
  // power-on release keeps the system in reset for a while
  AST_POR_HOLD: assert property ($rose(rst_b_i) |-> !sys_reset_n_o [*8])
    else $error("system reset released too soon after power-on");
  // every release finds the system reset already low eight cycles earlier
  AST_MIN_LOW: assert property ($rose(sys_reset_n_o) |-> !$past(sys_reset_n_o, 8))
    else $error("system reset pulse too short");
  AST_EXT_PIN: assert property (!ext_reset_n_i |=> !sys_reset_n_o)
    else $error("low external reset pin did not reset the system");
  AST_SUPPLY: assert property (supply_drop_reset_i |=> !sys_reset_n_o)
    else $error("supply drop did not reset the system");
  AST_SW_RESET: assert property (avs_write_i && !avs_waitrequest_o && sys_reset_n_o
      && avs_address_i == `SRW_OFF_CTRL && avs_writedata_i[`SRW_CTRL_SW_RST] |-> ##[1:4] !sys_reset_n_o)
    else $error("software reset write did not reset the system");
  AST_PROT_IRQ: assert property (prot_fault_irq_o |-> $past(prot_fault_i))
    else $error("protection interrupt without a fault");
  AST_HIB_WAKE: assert property (hibernate_freeze_o && wake_i && sys_reset_n_o |-> ##[1:4] !sys_reset_n_o)
    else $error("wakeup from hibernate did not reset");
  AST_IRQ_PULSE: assert property ((wdog_irq_o & $past(wdog_irq_o)) == '0)
    else $error("watchdog match event longer than one cycle");
  AST_DEEP_BOTH: assert property (sys_deep_sleep_o |-> $past(cpu_deep_i) == 2'b11)
    else $error("system deep sleep without both cpus in deep sleep");
  AST_HALT: assert property (($past(cpu_sleep_i | cpu_deep_i) & ~cpu_halt_o) == 2'b00)
    else $error("sleeping cpu not halted");
  AST_CLK_RATE: assert property (hf_clk_mhz_o == (vcore_ulp_o ? `SRW_HF_ULP_MHZ : `SRW_HF_LP_MHZ))
    else $error("main clock rate does not match the power mode");
  AST_FLL_SRC: assert property (hf_src_fll_o)
    else $error("main clock not taken from the locked loop");
endmodule // srw_top_sva
bind srw_top srw_top_sva chk_u (.mclk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_waitrequest_o, .ext_reset_n_i, .supply_drop_reset_i, .prot_fault_i, .cpu_sleep_i, .cpu_deep_i, .wake_i,
  .sys_reset_n_o, .wdog_irq_o, .prot_fault_irq_o, .cpu_halt_o, .sys_deep_sleep_o, .hibernate_freeze_o,
  .hf_src_fll_o, .hf_clk_mhz_o, .vcore_ulp_o);
`default_nettype wire

// ==== srw_wd_if.sv ====
// link between the controller and one watchdog counter
`timescale 1ns/1ps
`default_nettype none
interface srw_wd_if;
  logic en;
  logic tick;
  logic kick;
  logic clr_on_match;
  logic [31:0] match_val;
  logic [31:0] count;
  logic match_p;
  modport ctr (input en, tick, kick, clr_on_match, match_val, output count, match_p);
  modport ctl (output en, tick, kick, clr_on_match, match_val, input count, match_p);
endinterface // srw_wd_if
`default_nettype wire

// ==== srw_wdog_cnt.sv ====
// one watchdog counter of parameterised width
`timescale 1ns/1ps
`default_nettype none
module srw_wdog_cnt #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // control side
  srw_wd_if.ctr wd
);
  logic [W-1:0] cnt_reg;
  logic match_reg;
  wire hit = (cnt_reg == wd.match_val[W-1:0]);
  wire step = wd.en & wd.tick;

  // up-counter; a kick wins over a tick so service never loses to a count
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= '0;
      match_reg <= 1'b0;
    end else begin
      match_reg <= step & hit;
      if (wd.kick) begin
        cnt_reg <= '0;
      end else if (step) begin
        cnt_reg <= (hit & wd.clr_on_match) ? '0 : cnt_reg + 1'b1;
      end
    end
  end

  assign wd.count = 32'(cnt_reg);
  assign wd.match_p = match_reg;
endmodule // srw_wdog_cnt
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the reset, watchdog and power-mode controller
`timescale 1ns/1ps
`default_nettype none
`include "srw_defs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  import srw_pkg::*;
  logic mclk_i, rst_b_i, avs_read_i, avs_write_i, avs_waitrequest_o, ext_n, drop, prot_fault_i, wake_i;
  logic [7:0] avs_address_i, hf_clk_mhz_o;
  srw_word_t avs_writedata_i, avs_readdata_o, q, exp_cause;
  logic [1:0] cpu_sleep_i, cpu_deep_i, cpu_halt_o;
  logic [`SRW_N_WD-1:0] wdog_irq_o;
  logic sys_reset_n_o, prot_fault_irq_o, sys_deep_sleep_o, hibernate_freeze_o, hf_clk_en_o, hf_src_fll_o;
  logic vcore_ulp_o, periph_clk_en_o, ext_req, drop_req;
  logic [3:0] hold;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  srw_top dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ext_reset_n_i(ext_n), .supply_drop_reset_i(drop),
    .prot_fault_i(prot_fault_i), .cpu_sleep_i(cpu_sleep_i), .cpu_deep_i(cpu_deep_i), .wake_i(wake_i),
    .sys_reset_n_o(sys_reset_n_o), .wdog_irq_o(wdog_irq_o), .prot_fault_irq_o(prot_fault_irq_o),
    .cpu_halt_o(cpu_halt_o), .sys_deep_sleep_o(sys_deep_sleep_o), .hibernate_freeze_o(hibernate_freeze_o),
    .hf_clk_en_o(hf_clk_en_o), .hf_src_fll_o(hf_src_fll_o), .hf_clk_mhz_o(hf_clk_mhz_o),
    .vcore_ulp_o(vcore_ulp_o), .periph_clk_en_o(periph_clk_en_o));
  srw_partner far_u (.mclk_i(mclk_i), .ext_req_i(ext_req), .drop_req_i(drop_req), .hold_i(hold),
    .ext_reset_n_o(ext_n), .supply_drop_reset_o(drop));
  // 100 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard: the slowest runs wait a few watch crystal ticks of 3051 clocks
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails++;
      give_verdict();
    end
  end
  // one avalon transfer; request held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input srw_word_t d);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input srw_word_t e);
    bus(1'b0, a, 32'h0);
    `CHK($sformatf("reg 0x%0h", a), e, q)
  endtask
  // a system reset must come within n cycles and end again
  task wait_sysrst(input int n);
    int i;
    for (i = 0; i < n && sys_reset_n_o !== 1'b0; i++) @(posedge mclk_i);
    `CHK("reset entered", 1'b0, sys_reset_n_o)
    for (i = 0; i < 100 && sys_reset_n_o !== 1'b1; i++) @(posedge mclk_i);
    `CHK("reset left", 1'b1, sys_reset_n_o)
  endtask
  task pulse_prot;
    prot_fault_i <= 1'b1;
    @(posedge mclk_i);
    prot_fault_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  initial begin
    rst_b_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    prot_fault_i = 1'b0;
    wake_i = 1'b0;
    cpu_sleep_i = 2'b00;
    cpu_deep_i = 2'b00;
    ext_req = 1'b0;
    drop_req = 1'b0;
    hold = 4'h4;
    exp_cause = 32'h0000_0001;
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    wait_sysrst(1);
    rd(`SRW_OFF_CAUSE, exp_cause);
    rd(`SRW_OFF_CTRL, 32'h0);
    rd(8'h40, 32'h3);
    rd(8'h44, 32'h0000FFFF);
    rd(8'h3C, 32'h0);
    `CHK("clock source", 1'b1, hf_src_fll_o)
    `CHK("clock rate", 8'h32, hf_clk_mhz_o)
    `CHK("main clock", 1'b1, hf_clk_en_o)
    `CHK("peripheral clocks", 1'b0, periph_clk_en_o)
    bus(1'b1, 8'h40, 32'h0);
    bus(1'b1, `SRW_OFF_CTRL, 32'h34);
    repeat (2) @(posedge mclk_i);
    `CHK("core voltage", 1'b1, vcore_ulp_o)
    `CHK("clock rate", 8'h19, hf_clk_mhz_o)
    `CHK("peripheral clocks", 1'b1, periph_clk_en_o)
    rd(`SRW_OFF_STAT, 32'h40);
    // sleep halts one cpu; deep sleep needs both
    cpu_sleep_i <= 2'b01;
    cpu_deep_i <= 2'b10;
    repeat (3) @(posedge mclk_i);
    `CHK("halt", 2'b11, cpu_halt_o)
    `CHK("deep sleep", 1'b0, sys_deep_sleep_o)
    cpu_deep_i <= 2'b11;
    repeat (3) @(posedge mclk_i);
    `CHK("deep sleep", 1'b1, sys_deep_sleep_o)
    `CHK("main clock", 1'b0, hf_clk_en_o)
    `CHK("peripheral clocks", 1'b0, periph_clk_en_o)
    rd(`SRW_OFF_STAT, 32'h7D);
    cpu_deep_i <= 2'b01;
    repeat (3) @(posedge mclk_i);
    `CHK("deep sleep", 1'b0, sys_deep_sleep_o)
    cpu_deep_i <= 2'b00;
    cpu_sleep_i <= 2'b00;
    pulse_prot();
    `CHK("prot irq", 1'b1, prot_fault_irq_o)
    // first multi-counter 16-bit counter: match event, then reset on timeout
    bus(1'b1, 8'h54, 32'h2);
    bus(1'b1, 8'h50, 32'h5);
    for (int i = 0; i < 12000 && wdog_irq_o[1] !== 1'b1; i++) @(posedge mclk_i);
    `CHK("match event", 1'b1, wdog_irq_o[1])
    rd(8'h58, 32'h0);
    bus(1'b1, 8'h54, 32'h1);
    bus(1'b1, 8'h50, 32'h3);
    wait_sysrst(12000);
    exp_cause |= 32'h10;
    rd(`SRW_OFF_CAUSE, exp_cause);
    bus(1'b1, 8'h40, 32'h0);
    bus(1'b1, `SRW_OFF_CTRL, 32'h1);
    wait_sysrst(20);
    exp_cause |= 32'h40;
    rd(`SRW_OFF_CAUSE, exp_cause);
    bus(1'b1, `SRW_OFF_CTRL, 32'h2);
    pulse_prot();
    wait_sysrst(20);
    ext_req <= 1'b1;
    @(posedge mclk_i);
    ext_req <= 1'b0;
    wait_sysrst(20);
    hold <= 4'h9;
    drop_req <= 1'b1;
    @(posedge mclk_i);
    drop_req <= 1'b0;
    wait_sysrst(20);
    exp_cause |= 32'h86;
    rd(`SRW_OFF_CAUSE, exp_cause);
    // hibernate holds until a wakeup, which then resets
    bus(1'b1, 8'h40, 32'h0);
    bus(1'b1, `SRW_OFF_CTRL, 32'h8);
    cpu_deep_i <= 2'b11;
    repeat (3) @(posedge mclk_i);
    `CHK("freeze", 1'b1, hibernate_freeze_o)
    cpu_deep_i <= 2'b00;
    repeat (3) @(posedge mclk_i);
    `CHK("freeze", 1'b1, hibernate_freeze_o)
    wake_i <= 1'b1;
    @(posedge mclk_i);
    wake_i <= 1'b0;
    wait_sysrst(20);
    exp_cause |= 32'h100;
    rd(`SRW_OFF_CAUSE, exp_cause);
    bus(1'b1, `SRW_OFF_CAUSE, 32'h1FE);
    rd(`SRW_OFF_CAUSE, 32'h1);
    // basic watchdog match wakes from hibernate, and so resets
    bus(1'b1, 8'h40, 32'h5);
    bus(1'b1, 8'h44, 32'h1);
    bus(1'b1, `SRW_OFF_CTRL, 32'h8);
    cpu_deep_i <= 2'b11;
    repeat (2) @(posedge mclk_i);
    cpu_deep_i <= 2'b00;
    wait_sysrst(8000);
    rd(`SRW_OFF_CAUSE, 32'h101);
    // an unserviced basic watchdog resets the device
    bus(1'b1, 8'h44, 32'h1);
    wait_sysrst(8000);
    rd(`SRW_OFF_CAUSE, 32'h109);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
